/* File: logic/asr_defs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ASR_OFF_RX_STATUS 8'h00
`define ASR_OFF_RX_BUFFER 8'h04
`define ASR_OFF_TX_STATUS 8'h08
`define ASR_OFF_BAUD_CTRL 8'h0C
`define ASR_OFF_DIV_HIGH 8'h10
`define ASR_OFF_DIV_LOW 8'h14
`define ASR_OFF_INT_CTRL 8'h18

// ****************************************
// Field positions
// ****************************************
`define ASR_BIT_PORT_ENABLE 7
`define ASR_BIT_NINTH_EN 6
`define ASR_BIT_CONT_EN 4
`define ASR_BIT_ADDR_DET 3
`define ASR_BIT_SYNC_SEL 4
`define ASR_BIT_HIGH_SPEED 2
`define ASR_BIT_WIDE_DIV 3
`define ASR_BIT_WAKE_EN 1
`define ASR_BIT_GLOBAL_IE 7
`define ASR_BIT_PERIPH_IE 6
`define ASR_BIT_RX_PRIO 2
`define ASR_BIT_RX_IE 1

// ****************************************
// Reset values and timing counts
// ****************************************
`define ASR_RST_BYTE 8'h00
`define ASR_RST_DIV 16'h0000
`define ASR_OS_LAST 4'hF
`define ASR_OS_MID 4'h7
`define ASR_SLOW_PRE_LAST 2'h3
`define ASR_LAST_BIT_8 4'h7
`define ASR_LAST_BIT_9 4'h8
`define ASR_RESP_OKAY 2'h0
`define ASR_RESP_SLVERR 2'h2

`endif

/* File: logic/asr_pkg.sv */
// Types shared by the serial receiver modules
package asr_pkg;

  // Receiver states, one-hot
  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_start = 4'h2,
    st_data = 4'h4,
    st_stop = 4'h8
  } asr_state_t;

endpackage : asr_pkg

/* File: logic/asr_brg_if.sv */
// Link between receiver core and baud tick generator
`timescale 1ns/1ns
interface asr_brg_if;
  logic [15:0] divisor;
  logic fast;
  logic wide;
  logic run;
  logic tick;

  modport gen (input divisor, input fast, input wide, input run,
    output tick);
  modport user (output divisor, output fast, output wide, output run,
    input tick);
endinterface : asr_brg_if

/* File: logic/asr_baud_gen.sv */
// Baud tick generator at sixteen times the bit rate
`timescale 1ns/1ns
`include "asr_defs.svh"
module asr_baud_gen (
  input wire logic aclk,
  input wire logic aresetn,
  asr_brg_if.gen bus
);

  logic [15:0] cnt_q;
  logic [1:0] pre_q;
  logic [15:0] reload;

  // Eight-bit divisor unless the wide option is chosen
  assign reload = bus.wide ? bus.divisor : {8'h00, bus.divisor[7:0]};

  // Divisor counter; slow mode runs the generator at x64, /4 for x16
  always_ff @(posedge aclk) begin
    if (!aresetn || !bus.run) begin
      cnt_q <= `ASR_RST_DIV;
      pre_q <= 2'h0;
      bus.tick <= 1'h0;
    end else if (cnt_q == 16'h0000) begin
      cnt_q <= reload;
      pre_q <= pre_q + 2'h1;
      bus.tick <= bus.fast || (pre_q == `ASR_SLOW_PRE_LAST);
    end else begin
      cnt_q <= cnt_q - 16'h0001;
      bus.tick <= 1'h0;
    end
  end

endmodule : asr_baud_gen

/* File: logic/asr_rx_top.sv */
// Asynchronous serial receiver with address detect and wake-up
`timescale 1ns/1ns
`include "asr_defs.svh"
// Behaviour
// - Recover line data by sampling at sixteen times the bit rate.
// - Asynchronous operation only with sync select clear, port enabled.
// - Ninth-bit enable gives nine data bits, ninth kept in status.
// - Reception happens only while continuous receive is enabled.
// - Character done sets flag; interrupt only if receive enable set.
// - Low eight data bits appear in the receive buffer.
// - Clearing continuous receive clears latched errors.
// - Global and peripheral enables both needed for interrupts.
// - Priority bit routes the interrupt to high or low output.
// - Address detect enable with nine bits selects address mode.
// - With address detect cleared every character is loaded.
// - In sleep the divisor stops and no characters are received.
// - Wake enable suspends reception and holds the receiver idle.
// - Falling line edge is the wake event, asynchronous mode only.
// - Wake event sets the receive flag.
// - Reading the buffer clears the wake-raised flag.
// - First rising edge after wake clears wake enable.
// - Unimplemented register bits read as zero.
// - Frames are start bit, eight or nine data LSB first, stop.
// - Generator runs at x16 or x64 by speed and width options.
// - Receiver idle status bit readable by software.
module asr_rx_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic serial_receive_line,
  input wire logic sleep_mode,
  output logic irq_high,
  output logic irq_low
);

  // ****************************************
  // Declarations
  // ****************************************
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb_q;
  logic port_en_q, ninth_en_q, cont_en_q, addr_det_q;
  logic framing_error_flag_q, overrun_error_flag_q, ninth_q;
  logic sync_sel_q, high_speed_q, wide_div_q, wue_q;
  logic [7:0] div_hi_q, div_lo_q;
  logic gie_q, peripheral_interrupt_enable_q, receive_interrupt_enable_q, receive_interrupt_priority_q;
  logic [7:0] buf_q;
  logic full_q, wake_flag_q, wake_seen_q;
  logic irq_high_q, irq_low_q;
  asr_pkg::asr_state_t st_q;
  logic [3:0] os_q, bit_q;
  logic [8:0] sh_q;
  logic rx_meta_q, rx_sync_q, rx_prev_q;
  logic wr_en, rd_fire, rd_buf, async_md, rx_en, fall_e, rise_e;
  logic complete, char_ok, load, overrun, rx_flag, is_idle;
  logic rd_hit;
  logic [7:0] rd_val, data8;
  logic ninth_rx;
  asr_brg_if brg ();

  // Bus outputs straight from flops
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign irq_high = irq_high_q;
  assign irq_low = irq_low_q;

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  // Write fires once both address and data are held and byte lane 0 is strobed
  assign wr_en = !awready_q && !wready_q && !bvalid_q && wstrb_q;
  assign rd_fire = arvalid && arready_q;
  assign rd_buf = rd_fire && (araddr == `ASR_OFF_RX_BUFFER);

  // Write channels taken in either order, released after response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'h1;
      wready_q <= 1'h1;
      bvalid_q <= 1'h0;
      bresp_q <= `ASR_RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= `ASR_RST_BYTE;
      wstrb_q <= 1'h0;
    end else begin
      if (awvalid && awready_q) begin
        awready_q <= 1'h0;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready_q) begin
        wready_q <= 1'h0;
        wdata_q <= wdata[7:0];
        wstrb_q <= wstrb[0];
      end
      if (!awready_q && !wready_q && !bvalid_q) begin
        bvalid_q <= 1'h1;
        bresp_q <= (awaddr_q > `ASR_OFF_INT_CTRL || awaddr_q[1:0] != 2'h0)
          ? `ASR_RESP_SLVERR : `ASR_RESP_OKAY;
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'h0;
        awready_q <= 1'h1;
        wready_q <= 1'h1;
      end
    end
  end

  // Read data mux; unimplemented bits are zero
  always_comb begin
    rd_hit = 1'h1;
    case (araddr)
      `ASR_OFF_RX_STATUS: rd_val = {port_en_q, ninth_en_q, 1'h0,
        cont_en_q, addr_det_q, framing_error_flag_q, overrun_error_flag_q, ninth_q};
      `ASR_OFF_RX_BUFFER: rd_val = buf_q;
      `ASR_OFF_TX_STATUS: rd_val = {3'h0, sync_sel_q, 1'h0,
        high_speed_q, 2'h0};
      `ASR_OFF_BAUD_CTRL: rd_val = {1'h0, is_idle, 2'h0, wide_div_q,
        1'h0, wue_q, 1'h0};
      `ASR_OFF_DIV_HIGH: rd_val = div_hi_q;
      `ASR_OFF_DIV_LOW: rd_val = div_lo_q;
      `ASR_OFF_INT_CTRL: rd_val = {gie_q, peripheral_interrupt_enable_q, 3'h0, receive_interrupt_priority_q,
        receive_interrupt_enable_q, rx_flag};
      default: begin
        rd_val = `ASR_RST_BYTE;
        rd_hit = 1'h0;
      end
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'h1;
      rvalid_q <= 1'h0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ASR_RESP_OKAY;
    end else if (rd_fire) begin
      arready_q <= 1'h0;
      rvalid_q <= 1'h1;
      rdata_q <= {24'h00_0000, rd_val};
      rresp_q <= rd_hit ? `ASR_RESP_OKAY : `ASR_RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'h0;
      arready_q <= 1'h1;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Software-written control fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_en_q <= 1'h0;
      ninth_en_q <= 1'h0;
      cont_en_q <= 1'h0;
      addr_det_q <= 1'h0;
      sync_sel_q <= 1'h0;
      high_speed_q <= 1'h0;
      wide_div_q <= 1'h0;
      div_hi_q <= `ASR_RST_BYTE;
      div_lo_q <= `ASR_RST_BYTE;
      gie_q <= 1'h0;
      peripheral_interrupt_enable_q <= 1'h0;
      receive_interrupt_enable_q <= 1'h0;
      receive_interrupt_priority_q <= 1'h0;
    end else if (wr_en) begin
      case (awaddr_q)
        `ASR_OFF_RX_STATUS: begin
          port_en_q <= wdata_q[`ASR_BIT_PORT_ENABLE];
          ninth_en_q <= wdata_q[`ASR_BIT_NINTH_EN];
          cont_en_q <= wdata_q[`ASR_BIT_CONT_EN];
          addr_det_q <= wdata_q[`ASR_BIT_ADDR_DET];
        end
        `ASR_OFF_TX_STATUS: begin
          sync_sel_q <= wdata_q[`ASR_BIT_SYNC_SEL];
          high_speed_q <= wdata_q[`ASR_BIT_HIGH_SPEED];
        end
        `ASR_OFF_BAUD_CTRL: wide_div_q <= wdata_q[`ASR_BIT_WIDE_DIV];
        `ASR_OFF_DIV_HIGH: div_hi_q <= wdata_q;
        `ASR_OFF_DIV_LOW: div_lo_q <= wdata_q;
        `ASR_OFF_INT_CTRL: begin
          gie_q <= wdata_q[`ASR_BIT_GLOBAL_IE];
          peripheral_interrupt_enable_q <= wdata_q[`ASR_BIT_PERIPH_IE];
          receive_interrupt_priority_q <= wdata_q[`ASR_BIT_RX_PRIO];
          receive_interrupt_enable_q <= wdata_q[`ASR_BIT_RX_IE];
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // Line sampling and baud ticks
  // ****************************************
  // Two-flop synchroniser, then edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_q <= 1'h1;
      rx_sync_q <= 1'h1;
      rx_prev_q <= 1'h1;
    end else begin
      rx_meta_q <= serial_receive_line;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
    end
  end

  assign fall_e = rx_prev_q && !rx_sync_q;
  assign rise_e = !rx_prev_q && rx_sync_q;
  assign async_md = port_en_q && !sync_sel_q;
  // Reception gated by mode, enable, wake, sleep and overrun
  assign rx_en = async_md && cont_en_q && !wue_q && !sleep_mode
    && !overrun_error_flag_q;

  // Generator stops while asleep or out of asynchronous mode
  assign brg.divisor = {div_hi_q, div_lo_q};
  assign brg.fast = high_speed_q || wide_div_q;
  assign brg.wide = wide_div_q;
  assign brg.run = async_md && !sleep_mode;

  asr_baud_gen asr_baud_gen_inst (
    .aclk (aclk),
    .aresetn (aresetn),
    .bus (brg.gen)
  );

  // ****************************************
  // Receive state machine
  // ****************************************
  // Start at mid start bit, then one sample per sixteen ticks
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_en) begin
      st_q <= asr_pkg::st_idle;
      os_q <= 4'h0;
      bit_q <= 4'h0;
      sh_q <= 9'h000;
    end else if (brg.tick) begin
      case (st_q)
        asr_pkg::st_idle: begin
          os_q <= 4'h0;
          if (!rx_sync_q) begin
            st_q <= asr_pkg::st_start;
          end
        end
        asr_pkg::st_start: begin
          os_q <= os_q + 4'h1;
          if (os_q == `ASR_OS_MID) begin
            os_q <= 4'h0;
            bit_q <= 4'h0;
            st_q <= rx_sync_q ? asr_pkg::st_idle : asr_pkg::st_data;
          end
        end
        asr_pkg::st_data: begin
          os_q <= os_q + 4'h1;
          if (os_q == `ASR_OS_LAST) begin
            sh_q <= {rx_sync_q, sh_q[8:1]};
            bit_q <= bit_q + 4'h1;
            if (bit_q == (ninth_en_q ? `ASR_LAST_BIT_9
                : `ASR_LAST_BIT_8)) begin
              st_q <= asr_pkg::st_stop;
            end
          end
        end
        asr_pkg::st_stop: begin
          os_q <= os_q + 4'h1;
          if (os_q == `ASR_OS_LAST) begin
            st_q <= asr_pkg::st_idle;
          end
        end
        default: st_q <= asr_pkg::st_idle;
      endcase
    end
  end

  assign is_idle = (st_q == asr_pkg::st_idle);
  assign complete = (st_q == asr_pkg::st_stop) && brg.tick
    && (os_q == `ASR_OS_LAST) && rx_en;
  assign data8 = ninth_en_q ? sh_q[7:0] : sh_q[8:1];
  assign ninth_rx = ninth_en_q && sh_q[8];
  // Address mode keeps only characters with ninth bit set
  assign char_ok = !(addr_det_q && ninth_en_q && !ninth_rx);
  assign load = complete && char_ok && !full_q;
  assign overrun = complete && char_ok && full_q;

  // ****************************************
  // Receive buffer and error flags
  // ****************************************
  // Load wins over a buffer read in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_q <= `ASR_RST_BYTE;
      ninth_q <= 1'h0;
      full_q <= 1'h0;
    end else if (load) begin
      buf_q <= data8;
      ninth_q <= ninth_rx;
      full_q <= 1'h1;
    end else if (rd_buf) begin
      full_q <= 1'h0;
    end
  end

  // Overrun latches until continuous receive is cleared; framing error is rewritten on each load
  always_ff @(posedge aclk) begin
    if (!aresetn || !cont_en_q) begin
      framing_error_flag_q <= 1'h0;
      overrun_error_flag_q <= 1'h0;
    end else begin
      if (load) begin
        framing_error_flag_q <= !rx_sync_q;
      end
      if (overrun) begin
        overrun_error_flag_q <= 1'h1;
      end
    end
  end

  // ****************************************
  // Wake on falling edge
  // ****************************************
  // Software write to wake enable, hardware clear after wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wue_q <= 1'h0;
      wake_seen_q <= 1'h0;
    end else if (wr_en && awaddr_q == `ASR_OFF_BAUD_CTRL) begin
      wue_q <= wdata_q[`ASR_BIT_WAKE_EN];
      wake_seen_q <= 1'h0;
    end else if (wue_q && async_md) begin
      if (!wake_seen_q && fall_e) begin
        wake_seen_q <= 1'h1;
      end else if (wake_seen_q && rise_e) begin
        wue_q <= 1'h0;
        wake_seen_q <= 1'h0;
      end
    end
  end

  // Wake raises the receive flag, set wins over read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_flag_q <= 1'h0;
    end else if (wue_q && async_md && !wake_seen_q && fall_e) begin
      wake_flag_q <= 1'h1;
    end else if (rd_buf) begin
      wake_flag_q <= 1'h0;
    end
  end

  // ****************************************
  // Interrupt request outputs
  // ****************************************
  assign rx_flag = full_q || wake_flag_q;

  // Gated by enables, routed by priority
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_high_q <= 1'h0;
      irq_low_q <= 1'h0;
    end else begin
      irq_high_q <= rx_flag && receive_interrupt_enable_q && gie_q && peripheral_interrupt_enable_q && receive_interrupt_priority_q;
      irq_low_q <= rx_flag && receive_interrupt_enable_q && gie_q && peripheral_interrupt_enable_q && !receive_interrupt_priority_q;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence start_seen_s;
    is_idle && rx_en && brg.tick && !rx_sync_q;
  endsequence

  sequence wake_fall_s;
    wue_q && async_md && !wake_seen_q && fall_e && !wr_en;
  endsequence

  sequence wake_rise_s;
    wue_q && async_md && wake_seen_q && rise_e && !wr_en;
  endsequence

  start_detect_a: assert property (
    start_seen_s |=> st_q == asr_pkg::st_start)
    else $error("start bit not detected");
  irq_gate_a: assert property (
    (irq_high || irq_low) |-> $past(rx_flag && receive_interrupt_enable_q && gie_q && peripheral_interrupt_enable_q))
    else $error("interrupt without enabled flag");
  prio_route_a: assert property (
    irq_high |-> !irq_low && $past(receive_interrupt_priority_q))
    else $error("interrupt on wrong priority");
  async_only_a: assert property (
    !is_idle |-> $past(async_md && cont_en_q))
    else $error("receiving outside asynchronous mode");
  wake_hold_a: assert property (
    wue_q |=> is_idle)
    else $error("receiver active during wake watch");
  wake_flag_a: assert property (
    wake_fall_s |=> wake_flag_q && rx_flag)
    else $error("wake event lost");
  wake_clear_a: assert property (
    wake_rise_s |=> !wue_q && !wake_seen_q)
    else $error("wake enable not cleared");
  buf_clear_a: assert property (
    (rd_buf && !load) |=> !full_q)
    else $error("receive flag not cleared");
  wake_read_a: assert property (
    (rd_buf && !(wue_q && async_md && !wake_seen_q && fall_e))
      |=> !wake_flag_q)
    else $error("wake flag not cleared by read");
  addr_drop_a: assert property (
    (complete && addr_det_q && ninth_en_q && !ninth_rx) |=> $stable(buf_q)
      && (full_q == $past(full_q && !rd_buf)))
    else $error("address mode kept data character");
  overrun_stop_a: assert property (
    overrun |=> overrun_error_flag_q ##1 is_idle)
    else $error("overrun did not stop reception");

endmodule : asr_rx_top

/* File: verification/asr_line_model.sv */
// Remote asynchronous transmitter model driving the receive line
`timescale 1ns/1ns
module asr_line_model #(
  parameter int BIT_CLKS = 32
) (
  input wire logic aclk,
  input wire logic go,
  input wire logic [8:0] frame,
  input wire logic nine,
  input wire logic bad_stop,
  output logic line,
  output logic busy
);
  int i;
  // ****************************************
  // Frame sender
  // ****************************************
  initial begin
    line = 1'b1;
    busy = 1'b0;
  end
  // One frame per go pulse, then an idle gap
  always begin
    @(posedge aclk);
    if (go === 1'b1) begin
      busy <= 1'b1;
      line <= 1'b0;
      repeat (BIT_CLKS) @(posedge aclk);
      for (i = 0; i < (nine ? 9 : 8); i++) begin
        line <= frame[i];
        repeat (BIT_CLKS) @(posedge aclk);
      end
      // A bad stop stays low past mid-bit only
      line <= ~bad_stop;
      repeat (BIT_CLKS * 5 / 8) @(posedge aclk);
      line <= 1'b1;
      repeat (BIT_CLKS * 11 / 8) @(posedge aclk);
      busy <= 1'b0;
    end
  end
endmodule : asr_line_model

/* File: verification/asr_rx_top_bench.sv */
// Self-checking bench for the serial receiver
`timescale 1ns/1ns
`include "asr_defs.svh"
module asr_rx_top_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic irq_high, irq_low, line, busy;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata;
  logic sleep_mode = 1'b0, go = 1'b0, nine = 1'b0, bad = 1'b0;
  logic slow = 1'b0, line2, busy2;
  logic [8:0] frame = 9'h000;
  logic [7:0] got;
  int err_total = 0;
  int compares = 0;

  always #5 aclk = ~aclk;

  asr_rx_top #(.ADDR_W(8)) asr_rx_top_inst (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serial_receive_line(line & line2), .sleep_mode(sleep_mode),
    .irq_high(irq_high), .irq_low(irq_low));

  asr_line_model #(.BIT_CLKS(32)) asr_line_model_inst (.aclk(aclk),
    .go(go & !slow), .frame(frame), .nine(nine), .bad_stop(bad),
    .line(line), .busy(busy));

  // Slow-rate sender for the x64 generator path
  asr_line_model #(.BIT_CLKS(64)) asr_line_model_slow_inst (.aclk(aclk),
    .go(go & slow), .frame(frame), .nine(nine), .bad_stop(bad),
    .line(line2), .busy(busy2));

  // ****************************************
  // Reporting
  // ****************************************
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic oops(input string m);
    err_total++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : oops

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) oops($sformatf("got %h want %h", g, e));
  endtask : chk

  // ****************************************
  // Bus and line tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    bit aw, w;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1;
    w = 1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (!aw && !w && bvalid === 1'b1) break;
      if (aw && awready === 1'b1) begin
        aw = 0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 0;
        wvalid <= 1'b0;
      end
    end
    if (n == 100) begin
      oops("write timeout");
      give_verdict();
    end
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (rvalid === 1'b1) break;
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    if (n == 100) begin
      oops("read timeout");
      give_verdict();
    end
    got = rdata[7:0];
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic exp_rd(input logic [7:0] a, m, e);
    rd(a);
    chk(got & m, e);
  endtask : exp_rd

  task automatic xmit(input logic [8:0] f, input logic n9, b);
    int n;
    frame <= f;
    nine <= n9;
    bad <= b;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    for (n = 0; n < 1000; n++) begin
      @(posedge aclk);
      if ((busy | busy2) === 1'b0) break;
    end
    if (n == 1000) begin
      oops("line timeout");
      give_verdict();
    end
  endtask : xmit

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int a = 0; a < 28; a += 4) exp_rd(8'(a), 8'hBF, 8'h00);
    exp_rd(8'h1C, 8'hFF, 8'h00);
    chk({6'h00, resp}, 8'h02);
    wr(8'h1C, 8'h00);
    chk({6'h00, resp}, 8'h02);
    wr(`ASR_OFF_TX_STATUS, 8'hFF);
    chk({6'h00, resp}, 8'h00);
    exp_rd(`ASR_OFF_TX_STATUS, 8'hFF, 8'h14);
    chk({6'h00, resp}, 8'h00);
    wr(`ASR_OFF_RX_STATUS, 8'hFF);
    exp_rd(`ASR_OFF_RX_STATUS, 8'hFF, 8'hD8);
    wr(`ASR_OFF_DIV_HIGH, 8'hA5);
    exp_rd(`ASR_OFF_DIV_HIGH, 8'hFF, 8'hA5);
    $display("test registers done");
    // Two clocks per tick, 32 clocks per bit
    wr(`ASR_OFF_TX_STATUS, 8'h04);
    wr(`ASR_OFF_DIV_HIGH, 8'h00);
    wr(`ASR_OFF_DIV_LOW, 8'h01);
    wr(`ASR_OFF_BAUD_CTRL, 8'h08);
    wr(`ASR_OFF_INT_CTRL, 8'hC2);
    wr(`ASR_OFF_RX_STATUS, 8'h90);
    exp_rd(`ASR_OFF_BAUD_CTRL, 8'hFF, 8'h48);
    xmit(9'h0A5, 1'b0, 1'b0);
    chk({6'h00, irq_high, irq_low}, 8'h01);
    exp_rd(`ASR_OFF_INT_CTRL, 8'hFF, 8'hC3);
    exp_rd(`ASR_OFF_RX_STATUS, 8'hFF, 8'h90);
    exp_rd(`ASR_OFF_RX_BUFFER, 8'hFF, 8'hA5);
    exp_rd(`ASR_OFF_INT_CTRL, 8'hFF, 8'hC2);
    chk({6'h00, irq_high, irq_low}, 8'h00);
    wr(`ASR_OFF_INT_CTRL, 8'h82);
    xmit(9'h03C, 1'b0, 1'b0);
    chk({6'h00, irq_high, irq_low}, 8'h00);
    exp_rd(`ASR_OFF_INT_CTRL, 8'h01, 8'h01);
    wr(`ASR_OFF_INT_CTRL, 8'hC6);
    chk({6'h00, irq_high, irq_low}, 8'h02);
    exp_rd(`ASR_OFF_RX_BUFFER, 8'hFF, 8'h3C);
    wr(`ASR_OFF_INT_CTRL, 8'hC2);
    $display("test basic done");
    wr(`ASR_OFF_RX_STATUS, 8'hD0);
    xmit(9'h13C, 1'b1, 1'b0);
    exp_rd(`ASR_OFF_RX_STATUS, 8'hFF, 8'hD1);
    exp_rd(`ASR_OFF_RX_BUFFER, 8'hFF, 8'h3C);
    wr(`ASR_OFF_RX_STATUS, 8'hD8);
    xmit(9'h011, 1'b1, 1'b0);
    exp_rd(`ASR_OFF_INT_CTRL, 8'h01, 8'h00);
    xmit(9'h122, 1'b1, 1'b0);
    exp_rd(`ASR_OFF_INT_CTRL, 8'h01, 8'h01);
    exp_rd(`ASR_OFF_RX_BUFFER, 8'hFF, 8'h22);
    wr(`ASR_OFF_RX_STATUS, 8'hD0);
    xmit(9'h033, 1'b1, 1'b0);
    exp_rd(`ASR_OFF_INT_CTRL, 8'h01, 8'h01);
    exp_rd(`ASR_OFF_RX_BUFFER, 8'hFF, 8'h33);
    $display("test nine bit done");
    wr(`ASR_OFF_RX_STATUS, 8'h90);
    xmit(9'h05A, 1'b0, 1'b1);
    exp_rd(`ASR_OFF_RX_STATUS, 8'h04, 8'h04);
    xmit(9'h05B, 1'b0, 1'b0);
    exp_rd(`ASR_OFF_RX_STATUS, 8'h02, 8'h02);
    wr(`ASR_OFF_RX_STATUS, 8'h80);
    exp_rd(`ASR_OFF_RX_STATUS, 8'h06, 8'h00);
    exp_rd(`ASR_OFF_RX_BUFFER, 8'hFF, 8'h5A);
    $display("test errors done");
    // Continuous off, sync mode, then sleep: nothing received
    for (int k = 0; k < 3; k++) begin
      wr(`ASR_OFF_TX_STATUS, k == 1 ? 8'h14 : 8'h04);
      wr(`ASR_OFF_RX_STATUS, k == 0 ? 8'h80 : 8'h90);
      sleep_mode <= (k == 2);
      xmit(9'h0C3, 1'b0, 1'b0);
      exp_rd(`ASR_OFF_INT_CTRL, 8'h01, 8'h00);
      sleep_mode <= 1'b0;
    end
    wr(`ASR_OFF_TX_STATUS, 8'h04);
    $display("test blocked done");
    wr(`ASR_OFF_BAUD_CTRL, 8'h0A);
    xmit(9'h000, 1'b0, 1'b0);
    chk({6'h00, irq_high, irq_low}, 8'h01);
    exp_rd(`ASR_OFF_INT_CTRL, 8'h01, 8'h01);
    exp_rd(`ASR_OFF_BAUD_CTRL, 8'h02, 8'h00);
    rd(`ASR_OFF_RX_BUFFER);
    exp_rd(`ASR_OFF_INT_CTRL, 8'h01, 8'h00);
    xmit(9'h07E, 1'b0, 1'b0);
    exp_rd(`ASR_OFF_RX_BUFFER, 8'hFF, 8'h7E);
    $display("test wake done");
    // Slow x64 generator with 8-bit divisor: high byte must be ignored
    slow <= 1'b1;
    wr(`ASR_OFF_TX_STATUS, 8'h00);
    wr(`ASR_OFF_BAUD_CTRL, 8'h00);
    wr(`ASR_OFF_DIV_HIGH, 8'h5A);
    wr(`ASR_OFF_DIV_LOW, 8'h00);
    xmit(9'h0C5, 1'b0, 1'b0);
    exp_rd(`ASR_OFF_RX_BUFFER, 8'hFF, 8'hC5);
    $display("test slow done");
    give_verdict();
  end
endmodule : asr_rx_top_bench
